// ---- rtl/ats_map.vh ----
`ifndef ATS_MAP_VH
`define ATS_MAP_VH
`define ATS_ADDR_CTRL     12'h000
`define ATS_ADDR_COUNT    12'h004
`define ATS_ADDR_EXPOSE   12'h008
`define ATS_ADDR_READOUT  12'h00c
`define ATS_ADDR_PERIOD   12'h010
`define ATS_ADDR_CMD      12'h014
`define ATS_ADDR_STATUS   12'h018
`define ATS_ADDR_FRAMES   12'h01c
`define ATS_ADDR_DROPS    12'h020
`define ATS_CTRL_BURST_EN 0
`define ATS_CTRL_FRAME_EN 1
`define ATS_CMD_START     0
`define ATS_CTRL_RESET    2'h3
`define ATS_COUNT_RESET   16'h0003
`define ATS_EXPOSE_RESET  24'h000064
`define ATS_READOUT_RESET 24'h0000c8
`define ATS_PERIOD_RESET  24'h000190
`define ATS_ST_IDLE       1'h0
`define ATS_ST_WAIT       1'h1
`endif

// ---- rtl/ats_edge_sync.v ----
module ats_edge_sync (
  input  wire pclk,
  input  wire presetn,
  input  wire din,
  output reg  rise
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      rise <= 1'b0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      rise <= s2 & ~s3;
    end
  end
endmodule

// ---- rtl/ats_down_timer.v ----
module ats_down_timer #(
  parameter W = 24
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         load,
  input  wire [W-1:0] value,
  output wire         busy
);
  reg [W-1:0] count;
  assign busy = (count != {W{1'b0}});
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      count <= {W{1'b0}};
    else if (load)
      count <= value;
    else if (busy)
      count <= count - {{(W-1){1'b0}}, 1'b1};
  end
endmodule

// ---- rtl/ats_sequencer.v ----
`include "ats_map.vh"
module ats_sequencer #(
  parameter TW = 24,
  parameter CW = 16
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        line1,
  output reg         safe_to_fire_output,
  output reg         exposing,
  output reg         reading_out,
  output reg         burst_active
);
  reg [1:0]    ctrl;
  reg [CW-1:0] frame_count;
  reg [TW-1:0] expose_time;
  reg [TW-1:0] readout_time;
  reg [TW-1:0] period;
  reg          state;
  reg          next_state;
  reg [CW-1:0] frames;
  reg [CW-1:0] drops;
  reg [TW-1:0] gen_count;
  reg          sw_start;
  reg          exp_q;
  reg          rd_pending;
  wire         line_rise;
  wire         exp_busy;
  wire         rd_busy;
  wire         wr_en;
  wire         rd_en;
  wire         burst_req;
  wire         gen_tick;
  wire         frame_req;
  wire         trig_ok;
  wire         fire;
  wire         exp_end;
  wire         last_frame;
  wire [TW:0]  exp_plus;
  wire         safe_now;
  wire         setup_phase;
  reg [TW-1:0] rd_remaining;
  reg          next_exp_q;
  reg [CW-1:0] next_frames;
  reg [CW-1:0] next_drops;
  reg [TW-1:0] next_gen_count;
  reg [31:0]   next_prdata;
  reg          next_pslverr;
  reg          next_safe;
  reg          next_exposing;
  reg          next_burst_active;

  assign wr_en       = psel & penable & pwrite & pready;
  assign rd_en       = setup_phase & ~pwrite;
  assign setup_phase = psel & ~penable;

  ats_edge_sync u_line (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (line1),
    .rise    (line_rise)
  );

  ats_down_timer #(.W(TW)) u_exp (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (fire),
    .value   (expose_time),
    .busy    (exp_busy)
  );

  ats_down_timer #(.W(TW)) u_rd (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (exp_end),
    .value   (readout_time),
    .busy    (rd_busy)
  );

  // Burst start only via software command when enabled, else free-running
  assign burst_req = ctrl[`ATS_CTRL_BURST_EN] ? sw_start : 1'b1;
  assign gen_tick  = (gen_count == {TW{1'b0}});
  // External edge or internal generator
  assign frame_req = ctrl[`ATS_CTRL_FRAME_EN] ? line_rise : gen_tick;
  // Exposure ends only after prior readout cleared; remaining readout must fit
  assign exp_plus  = {1'b0, expose_time};
  assign safe_now  = ~exp_busy & ~exp_q & (exp_plus > {1'b0, rd_remaining});
  assign trig_ok   = safe_now;
  assign fire      = (state == `ATS_ST_WAIT) & frame_req & trig_ok;
  assign exp_end   = exp_q & ~exp_busy;
  assign last_frame = (frames + {{(CW-1){1'b0}}, 1'b1}) >= frame_count;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rd_remaining <= {TW{1'b0}};
    else if (exp_end)
      rd_remaining <= readout_time;
    else if (rd_remaining != {TW{1'b0}})
      rd_remaining <= rd_remaining - {{(TW-1){1'b0}}, 1'b1};
  end

  always @* begin
    next_state = state;
    case (state)
      `ATS_ST_IDLE: begin
        if (burst_req)
          next_state = `ATS_ST_WAIT;
      end
      `ATS_ST_WAIT: begin
        if (fire & last_frame)
          next_state = `ATS_ST_IDLE;
      end
      default: next_state = `ATS_ST_IDLE;
    endcase
  end

  // Sequencer state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state <= `ATS_ST_IDLE;
    else
      state <= next_state;
  end

  // Frames in burst
  always @* begin
    next_frames = frames;
    if (state == `ATS_ST_IDLE && burst_req)
      next_frames = {CW{1'b0}};
    else if (fire)
      next_frames = frames + {{(CW-1){1'b0}}, 1'b1};
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      frames <= {CW{1'b0}};
    else
      frames <= next_frames;
  end

  // Refused frame triggers
  always @* begin
    next_drops = drops;
    if (state == `ATS_ST_WAIT && frame_req && !trig_ok)
      next_drops = drops + {{(CW-1){1'b0}}, 1'b1};
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      drops <= {CW{1'b0}};
    else
      drops <= next_drops;
  end

  // Exposure phase flag
  always @* begin
    next_exp_q = exp_q;
    if (fire)
      next_exp_q = 1'b1;
    else if (!exp_busy)
      next_exp_q = 1'b0;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      exp_q <= 1'b0;
    else
      exp_q <= next_exp_q;
  end

  // Readout status bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rd_pending <= 1'b0;
    else
      rd_pending <= rd_busy;
  end

  // Internal frame period
  always @* begin
    next_gen_count = gen_count - {{(TW-1){1'b0}}, 1'b1};
    if (state != `ATS_ST_WAIT || gen_tick)
      next_gen_count = period;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      gen_count <= {TW{1'b0}};
    else
      gen_count <= next_gen_count;
  end

  // Control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl <= `ATS_CTRL_RESET;
    else if (wr_en && paddr == `ATS_ADDR_CTRL)
      ctrl <= pwdata[1:0];
  end

  // Burst frame count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      frame_count <= `ATS_COUNT_RESET;
    else if (wr_en && paddr == `ATS_ADDR_COUNT)
      frame_count <= pwdata[CW-1:0];
  end

  // Exposure length
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      expose_time <= `ATS_EXPOSE_RESET;
    else if (wr_en && paddr == `ATS_ADDR_EXPOSE)
      expose_time <= pwdata[TW-1:0];
  end

  // Readout length
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      readout_time <= `ATS_READOUT_RESET;
    else if (wr_en && paddr == `ATS_ADDR_READOUT)
      readout_time <= pwdata[TW-1:0];
  end

  // Internal frame period length
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      period <= `ATS_PERIOD_RESET;
    else if (wr_en && paddr == `ATS_ADDR_PERIOD)
      period <= pwdata[TW-1:0];
  end

  // Burst start command strobe
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sw_start <= 1'b0;
    else
      sw_start <= wr_en & (paddr == `ATS_ADDR_CMD) & pwdata[`ATS_CMD_START];
  end

  // Mapped address decode
  always @* begin
    case (paddr)
      `ATS_ADDR_CTRL, `ATS_ADDR_COUNT, `ATS_ADDR_EXPOSE, `ATS_ADDR_READOUT,
      `ATS_ADDR_PERIOD, `ATS_ADDR_CMD, `ATS_ADDR_STATUS, `ATS_ADDR_FRAMES,
      `ATS_ADDR_DROPS: next_pslverr = 1'b0;
      default:         next_pslverr = 1'b1;
    endcase
  end

  // Read data select
  always @* begin
    case (paddr)
      `ATS_ADDR_CTRL:    next_prdata = {30'h0, ctrl};
      `ATS_ADDR_COUNT:   next_prdata = {{(32-CW){1'b0}}, frame_count};
      `ATS_ADDR_EXPOSE:  next_prdata = {{(32-TW){1'b0}}, expose_time};
      `ATS_ADDR_READOUT: next_prdata = {{(32-TW){1'b0}}, readout_time};
      `ATS_ADDR_PERIOD:  next_prdata = {{(32-TW){1'b0}}, period};
      `ATS_ADDR_STATUS:  next_prdata = {28'h0, safe_to_fire_output, rd_pending, exp_q, state};
      `ATS_ADDR_FRAMES:  next_prdata = {{(32-CW){1'b0}}, frames};
      `ATS_ADDR_DROPS:   next_prdata = {{(32-CW){1'b0}}, drops};
      default:           next_prdata = 32'h00000000;
    endcase
  end

  // Bus response, one access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & next_pslverr;
      if (rd_en)
        prdata <= next_prdata;
    end
  end

  // Output decode
  always @* begin
    next_burst_active = (next_state == `ATS_ST_WAIT);
    next_safe         = next_burst_active & safe_now & ~fire;
    next_exposing     = fire | (exp_q & exp_busy);
  end

  // Outputs registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safe_to_fire_output <= 1'b0;
      exposing            <= 1'b0;
      reading_out         <= 1'b0;
      burst_active        <= 1'b0;
    end else begin
      safe_to_fire_output <= next_safe;
      exposing            <= next_exposing;
      reading_out         <= rd_busy;
      burst_active        <= next_burst_active;
    end
  end
endmodule

// ---- verif/ats_pulse_src.sv ----
module ats_pulse_src (
  input  wire  pclk,
  input  wire  fire,
  output logic line1
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold = 0;
  initial line1 = 1'b0;
  // Short clean pulse, low between pulses
  always @(posedge pclk) begin
    hold <= fire ? 3 : (hold > 0 ? hold - 1 : 0);
    line1 <= fire || hold > 1;
  end
endmodule

// ---- verif/ats_sequencer_checker.sv ----
`include "ats_map.vh"
module ats_sequencer_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  input wire        safe_to_fire_output,
  input wire        exposing,
  input wire        reading_out,
  input wire        burst_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_frame_in_burst: assert property ($rose(exposing) |-> $past(burst_active))
    else $error("exposure outside frame wait");
  a_safe_in_wait: assert property (safe_to_fire_output |-> burst_active)
    else $error("safe flag while idle");
  a_safe_drop: assert property ($rose(exposing) |-> !safe_to_fire_output)
    else $error("safe flag kept at start");
  a_safe_exposing: assert property (exposing |-> !safe_to_fire_output)
    else $error("safe during exposure");
  a_read_follow: assert property ($fell(exposing) |-> ##[0:1] reading_out)
    else $error("no readout after exposure");
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_unmapped: assert property (psel && penable && pready |->
    pslverr == (paddr > `ATS_ADDR_DROPS || paddr[1:0] != 2'h0))
    else $error("pslverr wrong");
endmodule
bind ats_sequencer ats_sequencer_checker chk (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
  .safe_to_fire_output, .exposing, .reading_out, .burst_active);

// ---- verif/ats_sequencer_test.sv ----
`include "ats_map.vh"
module ats_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, line1, safe, expo, rdo, burst, se;
  int          err_count = 0, cmp_count = 0, n;
  logic [44:0] rows[9] = '{{`ATS_ADDR_CTRL, 32'h3, 1'b0}, {`ATS_ADDR_COUNT, 32'h3, 1'b0},
    {`ATS_ADDR_EXPOSE, 32'h64, 1'b0}, {`ATS_ADDR_READOUT, 32'hc8, 1'b0}, {`ATS_ADDR_PERIOD, 32'h190, 1'b0},
    {`ATS_ADDR_STATUS, 32'h0, 1'b0}, {`ATS_ADDR_FRAMES, 32'h0, 1'b0}, {`ATS_ADDR_DROPS, 32'h0, 1'b0},
    {12'h024, 32'h0, 1'b1}};
  always #2.5 pclk = ~pclk;
  ats_sequencer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .line1, .safe_to_fire_output(safe), .exposing(expo), .reading_out(rdo), .burst_active(burst));
  ats_pulse_src src (.pclk, .fire, .line1);
  task chk(input string nm, input logic [31:0] ex, got);
    cmp_count++;
    if (got !== ex) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask
  task conclude;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    if (n == 20) begin
      chk("apb", 1, 0);
      conclude;
    end
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wt(input int k, input logic v);
    for (n = 0; n < 300 && (k == 0 ? burst : k == 1 ? expo : safe) !== v; n++) @(posedge pclk);
    if (n == 300) begin
      err_count++;
      conclude;
    end
  endtask
  task pulse;
    @(posedge pclk) fire <= 1;
    @(posedge pclk) fire <= 0;
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] ex);
    apb(a, 0, 0);
    chk("reg", ex, rd);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    foreach (rows[i]) begin
      apb(rows[i][44:33], 0, 0);
      chk("rd", rows[i][32:1], rd);
      chk("err", rows[i][0], se);
    end
    apb(`ATS_ADDR_EXPOSE, 1, 20);
    apb(`ATS_ADDR_READOUT, 1, 30);
    rdchk(`ATS_ADDR_EXPOSE, 20);
    pulse;
    repeat (20) @(posedge pclk);
    chk("idle", 0, expo);
    rdchk(`ATS_ADDR_DROPS, 0);
    apb(`ATS_ADDR_CMD, 1, 1);
    wt(0, 1);
    rdchk(`ATS_ADDR_FRAMES, 0);
    for (int i = 0; i < 2; i++) begin
      wt(2, 1);
      pulse;
      wt(1, 1);
      chk("ovl", i, rdo);
      pulse;
      wt(1, 0);
    end
    apb(`ATS_ADDR_CMD, 1, 1);
    rdchk(`ATS_ADDR_FRAMES, 2);
    wt(2, 1);
    pulse;
    wt(0, 0);
    rdchk(`ATS_ADDR_FRAMES, 3);
    pulse;
    repeat (20) @(posedge pclk);
    chk("after", 0, burst);
    rdchk(`ATS_ADDR_FRAMES, 3);
    rdchk(`ATS_ADDR_DROPS, 2);
    apb(`ATS_ADDR_PERIOD, 1, 40);
    apb(`ATS_ADDR_CTRL, 1, 1);
    apb(`ATS_ADDR_CMD, 1, 1);
    wt(0, 1);
    wt(0, 0);
    rdchk(`ATS_ADDR_FRAMES, 3);
    rdchk(`ATS_ADDR_DROPS, 2);
    apb(`ATS_ADDR_CTRL, 1, 2);
    wt(0, 1);
    @(posedge pclk) presetn <= 0;
    repeat (2) @(posedge pclk);
    chk("rst", 0, {burst, safe, expo, rdo});
    presetn <= 1;
    rdchk(`ATS_ADDR_CTRL, `ATS_CTRL_RESET);
    rdchk(`ATS_ADDR_FRAMES, 0);
    conclude;
  end
endmodule
